// *** tcc_timer_top.sv ***
// module: 16-bit timer counter with overflow and input capture channels
`timescale 1ns/10ps
`default_nettype none
module tcc_timer_top #(
  parameter int NUM_CH = 2
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [NUM_CH-1:0] i_ch_pin,
  output logic [7:0] o_rd_data,
  output logic o_irq
);
  import tcc_pkg::*;

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  // status register holds overflow plus one bit per channel
  if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_num_ch
    $error("NUM_CH must be 1 to 4");
  end

  localparam int ST_W = NUM_CH + 1;

  // true when address a selects register off of channel n
  function automatic logic ch_hit(input logic [7:0] a, input int n,
                                  input logic [7:0] off);
    ch_hit = (a == A_CH_BASE + 8'(n) * CH_STRIDE + off);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0] ctrl_r;
  logic [15:0] mod_r;
  logic [15:0] cnt_r;
  tcc_dir_t dir_r;
  logic [15:0] cbuf_r;
  logic cvld_r, chi_r, clo_r;
  logic [ST_W-1:0] st_r, msk_r, st_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic irq_r;
  logic run, cas, cnt_wr, rd_chi, rd_clo, ovf_evt;
  logic [15:0] term, cnt_view;
  logic [NUM_CH-1:0] cap_evt;
  logic [15:0] ch_val [NUM_CH];
  logic [7:0] ch_sc [NUM_CH];

  assign run = ctrl_r[CTRL_RUN];
  assign cas = ctrl_r[CTRL_CAS];
  assign cnt_wr = i_wr && (i_addr == A_CNT_HI || i_addr == A_CNT_LO);
  assign rd_chi = i_rd && (i_addr == A_CNT_HI);
  assign rd_clo = i_rd && (i_addr == A_CNT_LO);

  // either extreme modulus means the full 16-bit range
  assign term = (mod_r == CNT_ZERO || mod_r == CNT_ALL_ONES) ?
                CNT_ALL_ONES : mod_r;

  // overflow: wrap in up mode, turn-around at the top in center mode
  assign ovf_evt = run && !cnt_wr &&
                   (cas ? (dir_r == DIR_UP && cnt_r >= term)
                        : (cnt_r == term));

  // ----------------------------------------------------------------
  // control and modulus registers
  // ----------------------------------------------------------------
  // modulus is taken at once; a lowered modulus below the count only
  // takes effect after the next natural wrap in up mode
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= CTRL_RST;
      mod_r <= MOD_RST;
      msk_r <= ST_W'(MSK_RST);
    end else if (i_ce && i_wr) begin
      if (i_addr == A_CTRL) begin
        ctrl_r <= i_wr_data[1:0];
      end
      if (i_addr == A_MOD_HI) begin
        mod_r[15:8] <= i_wr_data;
      end
      if (i_addr == A_MOD_LO) begin
        mod_r[7:0] <= i_wr_data;
      end
      if (i_addr == A_IRQ_MSK) begin
        msk_r <= i_wr_data[ST_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // main counter
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= CNT_ZERO;
      dir_r <= DIR_UP;
    end else if (i_ce) begin
      if (cnt_wr) begin
        cnt_r <= CNT_ZERO;
        dir_r <= DIR_UP;
      end else if (run && !cas) begin
        dir_r <= DIR_UP;
        cnt_r <= (cnt_r == term) ? CNT_ZERO : cnt_r + CNT_ONE;
      end else if (run && dir_r == DIR_UP) begin
        // the top count stands one clock, then counting turns down
        if (cnt_r >= term) begin
          cnt_r <= cnt_r - CNT_ONE;
          dir_r <= DIR_DOWN;
        end else begin
          cnt_r <= cnt_r + CNT_ONE;
        end
      end else if (run) begin
        // zero stands one clock, then counting turns up again
        if (cnt_r == CNT_ZERO) begin
          cnt_r <= CNT_ONE;
          dir_r <= DIR_UP;
        end else begin
          cnt_r <= cnt_r - CNT_ONE;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // counter read pairing
  // ----------------------------------------------------------------
  // reads only touch the buffer, never the count itself
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cbuf_r <= CNT_ZERO;
      cvld_r <= 1'b0;
      chi_r <= 1'b0;
      clo_r <= 1'b0;
    end else if (i_ce) begin
      if (cnt_wr) begin
        cvld_r <= 1'b0;
        chi_r <= 1'b0;
        clo_r <= 1'b0;
      end else if (!cvld_r && (rd_chi || rd_clo)) begin
        cbuf_r <= cnt_r;
        cvld_r <= 1'b1;
        chi_r <= rd_chi;
        clo_r <= rd_clo;
      end else if ((chi_r || rd_chi) && (clo_r || rd_clo)) begin
        cvld_r <= 1'b0;
        chi_r <= 1'b0;
        clo_r <= 1'b0;
      end else begin
        chi_r <= chi_r || rd_chi;
        clo_r <= clo_r || rd_clo;
      end
    end
  end

  assign cnt_view = cvld_r ? cbuf_r : cnt_r;

  // ----------------------------------------------------------------
  // capture channels
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    tcc_ch_if chif ();
    assign chif.ce = i_ce;
    assign chif.cas = cas;
    assign chif.cnt = cnt_r;
    assign chif.wdata = i_wr_data;
    assign chif.wr_sc = i_wr && ch_hit(i_addr, i, CH_SC);
    assign chif.rd_hi = i_rd && ch_hit(i_addr, i, CH_VHI);
    assign chif.rd_lo = i_rd && ch_hit(i_addr, i, CH_VLO);
    assign ch_val[i] = chif.rd_val;
    assign ch_sc[i] = chif.sc;
    assign cap_evt[i] = chif.cap_pulse;
    tcc_capture_ch u_ch (
      .i_clk_sys (i_clk_sys),
      .i_rst (i_rst),
      .i_pin (i_ch_pin[i]),
      .bus (chif.chan)
    );
  end

  // ----------------------------------------------------------------
  // interrupt status, write one to clear
  // ----------------------------------------------------------------
  // a new event in the clearing cycle wins over the clear
  always_comb begin
    st_nxt = st_r;
    if (i_wr && i_addr == A_IRQ_ST) begin
      st_nxt = st_r & ~i_wr_data[ST_W-1:0];
    end
    st_nxt[ST_OVF] = st_nxt[ST_OVF] | ovf_evt;
    st_nxt[ST_CH0 +: NUM_CH] = st_nxt[ST_CH0 +: NUM_CH] | cap_evt;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
      irq_r <= 1'b0;
    end else if (i_ce) begin
      st_r <= st_nxt;
      irq_r <= |(st_r & msk_r);
    end
  end

  // ----------------------------------------------------------------
  // read data, valid only in the cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    rd_nxt = 8'h00;
    unique case (i_addr)
      A_CTRL: rd_nxt = {6'h00, ctrl_r};
      A_CNT_HI: rd_nxt = cnt_view[15:8];
      A_CNT_LO: rd_nxt = cnt_view[7:0];
      A_MOD_HI: rd_nxt = mod_r[15:8];
      A_MOD_LO: rd_nxt = mod_r[7:0];
      A_IRQ_ST: rd_nxt = 8'(st_r);
      A_IRQ_MSK: rd_nxt = 8'(msk_r);
      default: begin
        for (int n = 0; n < NUM_CH; n++) begin
          if (ch_hit(i_addr, n, CH_SC)) begin
            rd_nxt = ch_sc[n];
          end
          if (ch_hit(i_addr, n, CH_VHI)) begin
            rd_nxt = ch_val[n][15:8];
          end
          if (ch_hit(i_addr, n, CH_VLO)) begin
            rd_nxt = ch_val[n][7:0];
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rd_r <= 8'h00;
    end else if (i_ce) begin
      rd_r <= i_rd ? rd_nxt : 8'h00;
    end
  end

  assign o_rd_data = rd_r;
  assign o_irq = irq_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_top_turn;
    i_ce && run && cas && !cnt_wr && dir_r == DIR_UP && cnt_r == term;
  endsequence
  sequence s_bottom_turn;
    i_ce && run && cas && !cnt_wr && dir_r == DIR_DOWN &&
      cnt_r == CNT_ZERO;
  endsequence

  a_cnt_write_zero: assert property (
    (i_ce && cnt_wr) |=> (cnt_r == CNT_ZERO) && !cvld_r)
    else $error("counter write did not clear count and pairing");
  a_up_wrap: assert property (
    (i_ce && run && !cas && !cnt_wr && cnt_r == term) |=>
      (cnt_r == CNT_ZERO) && st_r[ST_OVF])
    else $error("up count did not wrap with overflow");
  a_center_top: assert property (
    s_top_turn |=> (cnt_r == $past(cnt_r) - CNT_ONE) &&
      st_r[ST_OVF] && dir_r == DIR_DOWN)
    else $error("center mode top turn wrong");
  a_center_bottom: assert property (
    s_bottom_turn |=> (cnt_r == CNT_ONE) && dir_r == DIR_UP)
    else $error("center mode bottom turn wrong");
  a_read_no_disturb: assert property (
    (i_ce && i_rd && run && !cas && !cnt_wr && cnt_r != term) |=>
      cnt_r == $past(cnt_r) + CNT_ONE)
    else $error("read disturbed the count");
  a_cnt_pair_freeze: assert property (
    (i_ce && rd_chi && !cvld_r) |=>
      cvld_r && (cbuf_r == $past(cnt_r)) &&
      (o_rd_data == $past(cnt_r[15:8])))
    else $error("counter pair not frozen on first read");
  a_irq_on: assert property (
    (i_ce && st_r[ST_OVF] && msk_r[ST_OVF]) |=> o_irq)
    else $error("enabled overflow gave no interrupt");
  a_irq_off: assert property (
    (i_ce && !(|(st_r & msk_r))) |=> !o_irq)
    else $error("interrupt without an enabled flag");

  // hi byte first, an idle cycle, then lo: the lo byte must come from
  // the buffer, and the pair is released once both bytes are read
  sequence s_cnt_hi_first;
    i_ce && rd_chi && !cvld_r && !cnt_wr;
  endsequence
  sequence s_cnt_gap;
    !cnt_wr && !rd_clo;
  endsequence
  sequence s_cnt_lo_read;
    i_ce && rd_clo;
  endsequence

  a_cnt_pair_lo: assert property (
    (s_cnt_hi_first ##1 s_cnt_gap ##1 s_cnt_lo_read) |=>
      (o_rd_data == $past(cnt_r[7:0], 3)) && !cvld_r)
    else $error("second counter byte not taken from the buffer");

  // the buffer may not refresh while a pair is half read
  a_cnt_buf_hold: assert property (
    (i_ce && cvld_r) |=> $stable(cbuf_r))
    else $error("counter buffer refreshed during a pair read");

  // a stopped counter keeps its value
  a_stop_hold: assert property (
    (i_ce && !run && !cnt_wr) |=> $stable(cnt_r))
    else $error("stopped counter moved");

  // counting down steps by one until zero is reached
  a_center_down: assert property (
    (i_ce && run && cas && !cnt_wr && dir_r == DIR_DOWN &&
      cnt_r != CNT_ZERO) |=> cnt_r == $past(cnt_r) - CNT_ONE)
    else $error("center mode down count wrong");

  // only the terminal count may raise the overflow flag in up mode
  a_no_stray_ovf: assert property (
    (i_ce && run && !cas && cnt_r != term && !st_r[ST_OVF]) |=>
      !st_r[ST_OVF])
    else $error("overflow flag set off the terminal count");
endmodule
`default_nettype wire

// *** tcc_pkg.sv ***
// package: register map, field positions and reset values of the timer
package tcc_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CNT_HI = 8'h01;
  localparam logic [7:0] A_CNT_LO = 8'h02;
  localparam logic [7:0] A_MOD_HI = 8'h03;
  localparam logic [7:0] A_MOD_LO = 8'h04;
  localparam logic [7:0] A_IRQ_ST = 8'h05;
  localparam logic [7:0] A_IRQ_MSK = 8'h06;
  localparam logic [7:0] A_CH_BASE = 8'h10;
  localparam logic [7:0] CH_STRIDE = 8'h04;
  localparam logic [7:0] CH_SC = 8'h00;
  localparam logic [7:0] CH_VHI = 8'h01;
  localparam logic [7:0] CH_VLO = 8'h02;
  // ----------------------------------------------------------------
  // field positions and encodings
  // ----------------------------------------------------------------
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CAS = 1;
  localparam int ST_OVF = 0;
  localparam int ST_CH0 = 1;
  localparam int SC_EDGE_LSB = 0;
  localparam int SC_MODE_LSB = 2;
  localparam logic [1:0] MODE_CAPTURE = 2'h0;
  localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [15:0] MOD_RST = 16'h0000;
  localparam logic [7:0] SC_RST = 8'h00;
  localparam logic [7:0] MSK_RST = 8'h00;
  typedef enum logic {DIR_UP, DIR_DOWN} tcc_dir_t;
endpackage

// *** tcc_ch_if.sv ***
// interface: link between the counter core and one capture channel
`timescale 1ns/10ps
`default_nettype none
interface tcc_ch_if;
  logic ce;
  logic cas;
  logic [15:0] cnt;
  logic wr_sc;
  logic rd_hi;
  logic rd_lo;
  logic [7:0] wdata;
  logic [7:0] sc;
  logic [15:0] rd_val;
  logic cap_pulse;
  modport core (output ce, cas, cnt, wr_sc, rd_hi, rd_lo, wdata,
                input sc, rd_val, cap_pulse);
  modport chan (input ce, cas, cnt, wr_sc, rd_hi, rd_lo, wdata,
                output sc, rd_val, cap_pulse);
endinterface
`default_nettype wire

// *** tcc_capture_ch.sv ***
// module: one input capture channel with coherent value readout
`timescale 1ns/10ps
`default_nettype none
module tcc_capture_ch (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_pin,
  tcc_ch_if.chan bus
);
  import tcc_pkg::*;
  logic sync1_r, sync2_r, prev_r;
  logic [7:0] sc_r;
  logic [15:0] val_r, buf_r;
  logic vld_r, hi_done_r, lo_done_r, cap_r;
  logic rise, fall, hit;
  logic [1:0] edge_sel, mode_sel;

  // two-stage synchroniser, then one stage for edge history
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else if (bus.ce) begin
      sync1_r <= i_pin;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // edge select bit 0 = rising, bit 1 = falling, both = any edge
  assign edge_sel = sc_r[SC_EDGE_LSB +: 2];
  assign mode_sel = sc_r[SC_MODE_LSB +: 2];
  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;
  assign hit = !bus.cas && (mode_sel == MODE_CAPTURE) &&
               ((edge_sel[0] && rise) || (edge_sel[1] && fall));

  // control register; a write also restarts the read pairing
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sc_r <= SC_RST;
    end else if (bus.ce && bus.wr_sc) begin
      sc_r <= bus.wdata;
    end
  end

  // capture the counter on an active edge
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      val_r <= CNT_ZERO;
      cap_r <= 1'b0;
    end else if (bus.ce) begin
      cap_r <= hit;
      if (hit) begin
        val_r <= bus.cnt;
      end
    end
  end

  // first byte read freezes the pair until the other byte is read
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      buf_r <= CNT_ZERO;
      vld_r <= 1'b0;
      hi_done_r <= 1'b0;
      lo_done_r <= 1'b0;
    end else if (bus.ce) begin
      if (bus.wr_sc) begin
        vld_r <= 1'b0;
        hi_done_r <= 1'b0;
        lo_done_r <= 1'b0;
      end else if (!vld_r && (bus.rd_hi || bus.rd_lo)) begin
        buf_r <= val_r;
        vld_r <= 1'b1;
        hi_done_r <= bus.rd_hi;
        lo_done_r <= bus.rd_lo;
      end else if ((hi_done_r || bus.rd_hi) && (lo_done_r || bus.rd_lo)) begin
        vld_r <= 1'b0;
        hi_done_r <= 1'b0;
        lo_done_r <= 1'b0;
      end
    end
  end

  assign bus.sc = sc_r;
  assign bus.rd_val = vld_r ? buf_r : val_r;
  assign bus.cap_pulse = cap_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_capture_latch: assert property (
    (bus.ce && hit) |=> (val_r == $past(bus.cnt)) && cap_r)
    else $error("capture did not latch the counter");
  a_sc_write_rst: assert property (
    (bus.ce && bus.wr_sc) |=> !vld_r)
    else $error("control write left the read pair frozen");
  a_ch_pair_hold: assert property (
    (bus.ce && !vld_r && bus.rd_hi && !bus.wr_sc) |=>
      vld_r && (bus.rd_val == $past(val_r)))
    else $error("capture value not frozen after first read");
endmodule
`default_nettype wire

// *** tcc_pin_model.sv ***
// partner model: external event source feeding the channel pins
`timescale 1ns/10ps
`default_nettype none
module tcc_pin_model #(
  parameter int NUM_CH = 2
) (
  input wire logic i_clk_sys,
  output logic [NUM_CH-1:0] o_pin
);
  // pins idle low until an event is commanded
  initial o_pin = '0;

  // level change after dly + 1 whole cycles, so both prompt and late events occur
  task automatic drive(input int ch, input logic lvl, input int dly);
    repeat (dly + 1) @(posedge i_clk_sys);
    o_pin[ch] <= lvl;
  endtask
endmodule
`default_nettype wire

// *** tcc_tb.sv ***
// testbench: timer counter with overflow interrupt and input capture
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tcc_pkg::*;
  localparam int NCH = 2;
  localparam int M = 5;
  localparam int LIMIT = 20000;
  logic i_clk_sys;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wr_data = 8'h00;
  logic [7:0] o_rd_data;
  logic [NCH-1:0] pins;
  logic o_irq;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int tr;
  int t1;
  logic [7:0] b;
  logic [15:0] v1;
  logic [15:0] v2;

  tcc_timer_top #(.NUM_CH(NCH)) uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_ce(i_ce), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr),
    .i_rd(i_rd), .i_ch_pin(pins), .o_rd_data(o_rd_data), .o_irq(o_irq));
  tcc_pin_model #(.NUM_CH(NCH)) pin_src (.i_clk_sys(i_clk_sys), .o_pin(pins));

  // 50 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  // cycle count doubles as the hang guard
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  // data is registered at the taking edge, so look just after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    d = o_rd_data;
    tr = cyc;
  endtask

  // byte pair read in either order; tr keeps the time of the first byte
  task automatic rdw(input logic [7:0] ha, input logic lo1,
                     output logic [15:0] v);
    logic [7:0] x;
    logic [7:0] y;
    int t;
    rd(lo1 ? ha + 8'h01 : ha, x);
    t = tr;
    rd(lo1 ? ha : ha + 8'h01, y);
    v = lo1 ? {y, x} : {x, y};
    tr = t;
  endtask

  task automatic wait_irq(output int t);
    int k;
    k = 0;
    do begin
      @(posedge i_clk_sys);
      #1;
      k++;
    end while (o_irq !== 1'b1 && k < 40);
    t = cyc;
  endtask

  // expected count of a modulus-5 counter, up (c=0) or up/down (c=1)
  function automatic logic [15:0] fw(input int t, input logic c);
    int k;
    k = c ? t % 10 : t % 6;
    return (k > 5) ? 16'(10 - k) : 16'(k);
  endfunction

  task automatic cap();
    pin_src.drive(0, ~pins[0], 0);
    repeat (6) @(posedge i_clk_sys);
  endtask

  // a short run so the stopped count moves on
  task automatic bump();
    wr(A_CTRL, 8'h01);
    wr(A_CTRL, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset();
    logic [7:0] a [8] = '{A_CTRL, A_MOD_HI, A_MOD_LO, A_IRQ_ST, A_IRQ_MSK,
                          A_CH_BASE, 8'h14, 8'h0f};
    wr(8'h0f, 8'hff);
    for (int i = 0; i < 8; i++) begin
      rd(a[i], b);
      chk(b, (i == 0) ? {6'h00, CTRL_RST} : 8'h00, "reset value");
    end
    chk(o_irq, 1'b0, "irq idle");
  endtask

  // lo byte first, a long gap ending in 40 cycles with the clock enable low, then the hi byte
  task automatic s_full(input logic [7:0] m);
    logic [7:0] x;
    wr(A_MOD_HI, m);
    wr(A_MOD_LO, m);
    wr(A_CNT_HI, 8'h00);
    rd(A_CNT_LO, b);
    t1 = tr;
    repeat (250) @(posedge i_clk_sys);
    i_ce <= 1'b0;
    repeat (40) @(posedge i_clk_sys);
    i_ce <= 1'b1;
    rd(A_CNT_HI, x);
    v1 = {x, b};
    rdw(A_CNT_HI, 1'b0, v2);
    chk(v2 - v1, 16'(tr - t1 - 40), "full range");
  endtask

  task automatic s_clear();
    wr(A_CTRL, 8'h00);
    rdw(A_CNT_HI, 1'b0, v1);
    rdw(A_CNT_HI, 1'b1, v2);
    chk(v2, v1, "stopped count");
    for (int i = 1; i < 3; i++) begin
      bump();
      rd(A_CNT_HI, b);
      wr(8'(i), 8'h5a);
      rd(A_CNT_LO, b);
      chk(b, 8'h00, "cleared lo");
      rd(A_CNT_HI, b);
      chk(b, 8'h00, "cleared hi");
    end
  endtask

  // fits sampled pairs to the wave, then times the overflow interrupt
  task automatic s_wave(input logic c);
    logic [15:0] v [6];
    int t [6];
    int p;
    int q;
    wr(A_MOD_HI, 8'h00);
    wr(A_MOD_LO, 8'(M));
    wr(A_CTRL, {6'h00, c, 1'b1});
    wr(A_CNT_LO, 8'h00);
    for (int i = 0; i < 6; i++) begin
      rdw(A_CNT_HI, i[0], v[i]);
      t[i] = tr;
    end
    p = 0;
    for (int k = 0; k < 10; k++) begin
      if (fw(k, c) == v[0] && fw(k + t[1] - t[0], c) == v[1]) p = k;
    end
    for (int i = 0; i < 6; i++) begin
      chk(v[i], fw(p + t[i] - t[0], c), "count wave");
    end
    wr(A_IRQ_MSK, 8'h01);
    wr(A_IRQ_ST, 8'hff);
    wait_irq(q);
    wr(A_IRQ_ST, 8'h01);
    wait_irq(p);
    chk(16'(p - q), c ? 16'h000a : 16'h0006, "irq period");
    wr(A_IRQ_MSK, 8'h00);
    repeat (12) @(posedge i_clk_sys);
    // step past the edge so the registered output has settled
    #1;
    chk(o_irq, 1'b0, "masked irq");
    rd(A_IRQ_ST, b);
    chk(b[ST_OVF], 1'b1, "polled flag");
  endtask

  // every edge code, mode codes 0 and 1, late rise and prompt fall, both channels
  task automatic s_edges();
    logic [7:0] sc [6] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h05, 8'h01};
    logic e;
    for (int c = 0; c < NCH; c++) begin
      for (int i = 0; i < 6; i++) begin
        wr(A_CTRL, (i == 5) ? 8'h03 : 8'h01);
        wr(A_CH_BASE + 8'(c) * CH_STRIDE, sc[i]);
        for (int l = 1; l >= 0; l--) begin
          wr(A_IRQ_ST, 8'hfe);
          pin_src.drive(c, l[0], 3 * l);
          repeat (6) @(posedge i_clk_sys);
          rd(A_IRQ_ST, b);
          e = (i < 4) && sc[i][1 - l];
          chk(b[ST_CH0 + c], e, "capture event");
        end
      end
    end
  endtask

  // stopped counter gives exact captured values
  task automatic s_value();
    logic [15:0] x;
    wr(A_CTRL, 8'h00);
    wr(A_CH_BASE, 8'h03);
    rdw(A_CNT_HI, 1'b0, x);
    cap();
    rdw(A_CH_BASE + CH_VHI, 1'b1, v1);
    chk(v1, x, "captured value");
    rd(A_CH_BASE + CH_VHI, b);
    bump();
    rdw(A_CNT_HI, 1'b0, x);
    cap();
    rd(A_CH_BASE + CH_VLO, b);
    chk(b, v1[7:0], "frozen lo");
    rd(A_CH_BASE + CH_VHI, b);
    chk(b, x[15:8], "new hi");
    rd(A_CH_BASE + CH_VLO, b);
    chk(b, x[7:0], "new lo");
    // leave a half-read pair for the control write to abandon
    rd(A_CH_BASE + CH_VHI, b);
    bump();
    rdw(A_CNT_HI, 1'b0, v2);
    cap();
    wr(A_CH_BASE, 8'h03);
    rd(A_CH_BASE + CH_VLO, b);
    chk(b, v2[7:0], "pairing restart");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    s_reset();
    s_full(8'h00);
    s_full(8'hff);
    s_clear();
    s_wave(1'b0);
    s_wave(1'b1);
    s_edges();
    s_value();
    report_and_stop();
  end
endmodule
`default_nettype wire
